// >>> bench/pmu_wakeup_checker.sv
// Port-level assertions for the wake-up logic.
module pmu_wakeup_checker
	import wakeup_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire apb_req_type apb_req,
	input wire apb_rsp_type apb_rsp,
	input wire wake_lines_type wake_lines,
	input wire logic temp_on,
	input wire power_mode_type power_mode,
	input wire logic go_high_speed,
	input wire logic activity_pulse
);
	// *****************
	// Checks
	// *****************
	logic deep;
	// Deep modes with no temporary-on routine running.
	assign deep = (power_mode inside {mode_sleep, mode_suspend, mode_off}) && !temp_on;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	ready_one_cycle_a: assert property (apb_rsp.pready |=> !apb_rsp.pready)
		else $error("pready stood longer than one cycle");
	one_wait_state_a: assert property (apb_req.psel && apb_req.penable && !apb_rsp.pready
		|=> apb_rsp.pready)
		else $error("access phase not answered after one wait");
	error_with_ready_a: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
		else $error("pslverr without pready");
	rdata_idle_a: assert property (!apb_rsp.pready |-> apb_rsp.prdata == 32'h0)
		else $error("read data outside answer cycle");
	no_wake_high_a: assert property (power_mode == mode_high |=> !go_high_speed)
		else $error("wake demand in high speed mode");
	temp_on_hold_a: assert property (temp_on |=> !go_high_speed)
		else $error("wake serviced during temporary-on");
	pulse_single_a: assert property (activity_pulse |=> !activity_pulse)
		else $error("activity pulse longer than one cycle");
	pulse_with_wake_a: assert property (activity_pulse |-> go_high_speed)
		else $error("activity pulse without wake");
	pin_always_wakes_a: assert property (($changed(wake_lines.suspend_resume_pin) && deep)
		##1 deep [*6] |-> go_high_speed)
		else $error("suspend resume edge did not wake");
	// The main scenarios should all be reached.
	wake_seen_c: cover property ($rose(go_high_speed));
	pulse_seen_c: cover property (activity_pulse);
	slverr_seen_c: cover property (apb_rsp.pslverr);
endmodule // pmu_wakeup_checker

bind pmu_wakeup_logic pmu_wakeup_checker pmu_wakeup_checker_i (.mclk(mclk), .rst_n(rst_n),
	.apb_req(apb_req), .apb_rsp(apb_rsp), .wake_lines(wake_lines), .temp_on(temp_on),
	.power_mode(power_mode), .go_high_speed(go_high_speed), .activity_pulse(activity_pulse));

// >>> bench/tb_top.sv
// Self-checking bench for the wake-up logic.
`include "wakeup_regs.svh"
module tb_top
	import wakeup_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	apb_req_type req = '0;
	apb_rsp_type rsp;
	wake_lines_type wl;
	logic [2:0] pic = 3'h0;
	logic refresh = 1'b0;
	logic [2:0] ack = 3'h0;
	logic temp_on = 1'b0;
	power_mode_type mode = mode_high;
	logic go_hs;
	logic act;
	logic [3:0] src = 4'h0;
	logic fire = 1'b0;
	logic rel = 1'b0;
	logic [7:0] rw_idx [4] = '{`IDX_RESUME_MASK, `IDX_ACT_MASK_ONE, `IDX_PWR_CTRL_THREE,
		`IDX_WAKE_CONFIG};
	int err_total = 0;
	int samples_checked = 0;
	int cyc = 0;
	// *****************
	// Clock and instances
	// *****************
	always #20 mclk = ~mclk;
	pmu_wakeup_logic pmu_wakeup_logic_i (.mclk(mclk), .rst_n(rst_n), .apb_req(req),
		.apb_rsp(rsp), .wake_lines(wl), .pic_mask(pic), .irq_ack_eoi(ack),
		.refresh(refresh), .temp_on(temp_on), .power_mode(mode),
		.go_high_speed(go_hs), .activity_pulse(act));
	wake_peer wake_peer_i (.mclk(mclk), .src(src), .fire(fire), .rel(rel), .wake_lines(wl));
	// *****************
	// Tasks
	// *****************
	task automatic tally_and_finish();
		if (err_total == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// The request is held until the edge that samples pready high.
	task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d,
		output logic [31:0] q, output logic e);
		@(posedge mclk);
		req <= '{1'b1, 1'b0, w, {2'h0, idx, 2'h0}, {24'h0, d}};
		@(posedge mclk);
		req.penable <= 1'b1;
		do @(posedge mclk); while (rsp.pready !== 1'b1);
		q = rsp.prdata;
		e = rsp.pslverr;
		req <= '0;
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, idx, d, q, e);
	endtask
	task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input logic ee);
		logic [31:0] q;
		logic e;
		apb(1'b0, idx, 8'h00, q, e);
		chk("prdata", exp, q);
		chk("pslverr", {31'h0, ee}, {31'h0, e});
	endtask
	task automatic poke(input logic [3:0] s, input int n, output logic g, output logic p);
		@(posedge mclk);
		src <= s;
		fire <= 1'b1;
		@(posedge mclk);
		fire <= 1'b0;
		g = 1'b0;
		p = 1'b0;
		repeat (n) begin
			@(posedge mclk);
			g |= go_hs;
			p |= act;
		end
	endtask
	// Back to high speed, lines released, a refresh, then flags cleared.
	task automatic settle();
		@(posedge mclk);
		mode <= mode_high;
		temp_on <= 1'b0;
		rel <= 1'b1;
		@(posedge mclk);
		rel <= 1'b0;
		refresh <= 1'b1;
		@(posedge mclk);
		refresh <= 1'b0;
		repeat (6) @(posedge mclk);
		wr(`IDX_RESUME_FLAGS, 8'h00);
		wr(`IDX_ACT_FLAGS, 8'h00);
	endtask
	// Expected wake for a source index under the given masks.
	function automatic logic want(input logic [3:0] s, input logic [7:0] am, input logic [7:0] rm,
		input logic [7:0] pc, input logic [2:0] pm, input logic lb);
		case (s)
			0: return am[0];
			1: return am[2];
			2: return am[2] && !lb;
			3: return am[3];
			4, 5: return am[3] && !lb;
			6: return am[4];
			7: return rm[3] && !pm[0];
			8: return rm[4] && !pm[1];
			9: return rm[6] && !pm[2];
			10: return rm[5];
			11: return am[6] && pc[4];
			default: return 1'b1;
		endcase
	endfunction
	// Hang guard: the run needs a few thousand cycles.
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			tally_and_finish();
		end
	end
	// *****************
	// Main sequence
	// *****************
	initial begin
		logic [7:0] am, rm, pc, v;
		logic [2:0] pm, md;
		logic lb, g, p, w;
		logic [3:0] s;
		void'($urandom(58355));
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		rd(`IDX_RESUME_FLAGS, 32'h0, 1'b0);
		rd(`IDX_ACT_FLAGS, 32'h0, 1'b0);
		foreach (rw_idx[k]) begin
			v = $urandom;
			rd(rw_idx[k], 32'h0, 1'b0);
			wr(rw_idx[k], v);
			rd(rw_idx[k], {24'h0, v}, 1'b0);
		end
		rd(8'h01, 32'h0, 1'b1);
		for (int i = 0; i < 40; i++) begin
			s = (i < 13) ? 4'(i) : 4'($urandom_range(12));
			am = $urandom;
			rm = $urandom;
			pc = $urandom;
			pm = $urandom;
			lb = $urandom;
			md = 3'($urandom_range(5, 1));
			w = want(s, am, rm, pc, pm, lb);
			wr(`IDX_ACT_MASK_ONE, am);
			wr(`IDX_RESUME_MASK, rm);
			wr(`IDX_PWR_CTRL_THREE, pc);
			wr(`IDX_WAKE_CONFIG, {7'h00, lb});
			pic <= pm;
			mode <= power_mode_type'(md);
			poke(s, 12, g, p);
			chk("go_high_speed", {31'h0, w}, {31'h0, g});
			chk("activity_pulse", {31'h0, w && md < 3}, {31'h0, p});
			settle();
		end
		mode <= mode_suspend;
		temp_on <= 1'b1;
		poke(4'hC, 10, g, p);
		chk("go_high_speed", 32'h0, {31'h0, g});
		temp_on <= 1'b0;
		poke(4'hF, 0, g, p);
		repeat (8) begin
			@(posedge mclk);
			g |= go_hs;
		end
		chk("go_high_speed", 32'h1, {31'h0, g});
		settle();
		wr(`IDX_RESUME_MASK, 8'h20);
		mode <= mode_sleep;
		poke(4'hA, 6, g, p);
		wr(`IDX_RESUME_FLAGS, 8'h00);
		rd(`IDX_RESUME_FLAGS, 32'h20, 1'b0);
		// The second clear follows a refresh, so the ring flag must go.
		refresh <= 1'b1;
		@(posedge mclk);
		refresh <= 1'b0;
		wr(`IDX_RESUME_FLAGS, 8'h00);
		rd(`IDX_RESUME_FLAGS, 32'h0, 1'b0);
		settle();
		// An acknowledge with end-of-interrupt drops a held interrupt wake-up.
		wr(`IDX_RESUME_MASK, 8'h08);
		pic <= 3'h0;
		mode <= mode_sleep;
		poke(4'h7, 6, g, p);
		chk("go_high_speed", 32'h1, {31'h0, g});
		ack <= 3'h1;
		@(posedge mclk);
		ack <= 3'h0;
		repeat (4) @(posedge mclk);
		chk("go_high_speed", 32'h0, {31'h0, go_hs});
		settle();
		rd(`IDX_RESUME_FLAGS, 32'h0, 1'b0);
		tally_and_finish();
	end
endmodule // tb_top

// >>> bench/wake_peer.sv
// Model of the peripherals that drive the wake-up lines.
module wake_peer
	import wakeup_pkg::*;
(
	input wire logic mclk,
	input wire logic [3:0] src,
	input wire logic fire,
	input wire logic rel,
	output wake_lines_type wake_lines
);
	timeunit 1ns;
	timeprecision 1ns;
	initial wake_lines = '{drq: 8'h00, ring_n: 1'b1, default: 1'b0};
	// Levels except the one-cycle ring_n pulse and the toggled suspend/resume pin are held until released, since the device may still be asleep.
	always @(posedge mclk) begin
		wake_lines.ring_n <= 1'b1;
		if (fire) begin
			case (src)
				0, 1, 2: wake_lines.drq[src + 4'h1] <= 1'b1;
				3, 4, 5: wake_lines.drq[src + 4'h2] <= 1'b1;
				6: wake_lines.irq1 <= 1'b1;
				7: wake_lines.irq3 <= 1'b1;
				8: wake_lines.irq4 <= 1'b1;
				9: wake_lines.irq8 <= 1'b1;
				10: wake_lines.ring_n <= 1'b0;
				11: wake_lines.ac_power_present <= 1'b1;
				default: wake_lines.suspend_resume_pin <= ~wake_lines.suspend_resume_pin;
			endcase
		end
		// Every line but the suspend/resume pin drops between tries so no line blocks the shared edge detector.
		if (rel) begin
			wake_lines <= '{drq: 8'h00, ring_n: 1'b1, default: 1'b0,
				suspend_resume_pin: wake_lines.suspend_resume_pin};
		end
	end
endmodule // wake_peer

// >>> hw/pmu_wakeup_logic.sv
// Wake-up logic of the power manager with its APB register file.
// Behaviour
// - Enabled wake-up leaves deep modes to high speed.
// - In slow modes a wake-up counts as activity.
// - DRQ lines wake on rise, held until low.
// - Keyboard interrupt wakes on rise, unmasked.
// - IRQ3/4/8 wake on rise, PIC-masked, ack clears.
// - Ring wakes on fall, flag held to refresh.
// - Resume mask enables ring, IRQ3/4, IRQ8.
// - DRQ2 rise enabled by activity mask bit 2.
// - Power-present rise needs two enable bits.
// - Keyboard interrupt enabled by activity bit 4.
// - Full bus selects DRQ1-3, DRQ5-7 by bits.
// - Local bus allows only DRQ1, 2, 5.
// - No glitch filter on interrupt wake lines.
// - DRQ and IRQ lines ORed before edge detect.
// - Wake-up during temporary-on waits until it ends.
// - Acknowledge during temporary-on consumes the wake-up.
// - Suspend/resume pin edge always wakes, unmaskable.
// - Detected events set flags; any write clears.
//
// The APB interface to the registers was decided locally.
`include "wakeup_regs.svh"
module pmu_wakeup_logic
	import wakeup_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire apb_req_type apb_req,
	output apb_rsp_type apb_rsp,
	input wire wake_lines_type wake_lines,
	input wire logic [2:0] pic_mask,
	input wire logic [2:0] irq_ack_eoi,
	input wire logic refresh,
	input wire logic temp_on,
	input wire power_mode_type power_mode,
	output logic go_high_speed,
	output logic activity_pulse
);

	// ************************************************************
	// State
	// ************************************************************

	typedef struct packed {
		logic [`IN_COUNT-1:0] sync_one;
		logic [`IN_COUNT-1:0] sync_two;
		logic [`IN_COUNT-1:0] last;
		logic or_last;
		logic [`SRC_COUNT-1:0] pending;
		logic ring_latch;
		logic held;
		logic [7:0] resume_enable_mask;
		logic [7:0] resume_event_flags;
		logic [7:0] activity_enable_mask_one;
		logic [7:0] activity_event_flags;
		logic [7:0] power_control_three;
		logic [7:0] wake_config;
		apb_rsp_type rsp;
		logic go_hs;
		logic act;
	} state_type;

	state_type state_reg;
	state_type state_next;

	// ************************************************************
	// Decoding helpers
	// ************************************************************

	// Which of the ORed sources may cause a wake-up right now.
	function automatic logic [`SRC_COUNT-1:0] src_enable(
		input logic [7:0] am,
		input logic [7:0] rm,
		input logic local_bus,
		input logic [2:0] pm
	);
		logic [`SRC_COUNT-1:0] en;
		en = `RESET_SRC;
		en[0] = am[`AM_DRQ1];
		en[1] = am[`AM_DRQ23];
		en[2] = am[`AM_DRQ23] & ~local_bus;
		en[3] = am[`AM_DRQ567];
		en[4] = am[`AM_DRQ567] & ~local_bus;
		en[5] = am[`AM_DRQ567] & ~local_bus;
		en[6] = am[`AM_IRQ1];
		en[7] = rm[`RM_IRQ3] & ~pm[0];
		en[8] = rm[`RM_IRQ4] & ~pm[1];
		en[9] = rm[`RM_IRQ8] & ~pm[2];
		return en;
	endfunction

	// Register index from a byte address; misaligned gives no hit.
	function automatic logic [8:0] reg_index(input logic [11:0] addr);
		logic [8:0] idx;
		idx = {1'b0, addr[9:2]};
		if (addr[1:0] != 2'b00 || addr[11:10] != 2'b00) begin
			idx = 9'h1FF;
		end
		return idx;
	endfunction

	// True while the manager sits in a deep mode.
	function automatic logic is_deep(input power_mode_type m);
		return (m == mode_sleep) || (m == mode_suspend) || (m == mode_off);
	endfunction

	// True while the manager sits in a slow clock mode.
	function automatic logic is_slow(input power_mode_type m);
		return (m == mode_low) || (m == mode_doze);
	endfunction

	// ************************************************************
	// Input gathering
	// ************************************************************

	logic [`IN_COUNT-1:0] raw_lines;
	logic [`SRC_COUNT-1:0] src_now;
	logic [`SRC_COUNT-1:0] src_en;
	logic or_now;
	logic or_rise;
	logic ring_fall;
	logic ac_power_present_rise;
	logic susres_edge;
	logic [8:0] idx;
	logic access;
	logic hit;
	logic [7:0] rd_byte;
	logic demand;
	logic service;
	logic [7:0] resume_set;
	logic [7:0] activity_set;

	// Order the lines into one vector; drq bits 0 and 4 are unused.
	assign raw_lines = {
		wake_lines.suspend_resume_pin,
		wake_lines.ac_power_present,
		wake_lines.ring_n,
		wake_lines.irq8,
		wake_lines.irq4,
		wake_lines.irq3,
		wake_lines.irq1,
		wake_lines.drq[7],
		wake_lines.drq[6],
		wake_lines.drq[5],
		wake_lines.drq[3],
		wake_lines.drq[2],
		wake_lines.drq[1]
	};

	// ************************************************************
	// Next state
	// ************************************************************

	always_comb begin
		state_next = state_reg;
		// Two flops bring every line into the clock domain; no filter.
		state_next.sync_one = raw_lines;
		state_next.sync_two = state_reg.sync_one;
		state_next.last = state_reg.sync_two;
		src_now = state_reg.sync_two[`SRC_COUNT-1:0];
		src_en = src_enable(state_reg.activity_enable_mask_one,
			state_reg.resume_enable_mask,
			state_reg.wake_config[`CFG_LOCAL_BUS], pic_mask);
		// A single detector on the OR of all DRQ and IRQ lines, masked or not, so a
		// stuck line hides the edges of the others.
		or_now = |src_now;
		state_next.or_last = or_now;
		or_rise = or_now & ~state_reg.or_last;
		ring_fall = state_reg.last[10] & ~state_reg.sync_two[10];
		ac_power_present_rise = state_reg.sync_two[11] & ~state_reg.last[11];
		susres_edge = state_reg.sync_two[12] ^ state_reg.last[12];

		// Line events stay active while the line is high; an acknowledge
		// with end-of-interrupt drops an interrupt event, even inside a
		// temporary-on routine, where it is then lost.
		state_next.pending = state_reg.pending;
		if (or_rise) begin
			state_next.pending = state_reg.pending | (src_en & src_now);
		end
		state_next.pending = state_next.pending & src_now;
		state_next.pending[9:7] = state_next.pending[9:7] & ~irq_ack_eoi;

		// Ring flag lasts until the next refresh unless a new fall arrives.
		state_next.ring_latch = state_reg.ring_latch;
		if (refresh) begin
			state_next.ring_latch = 1'b0;
		end
		if (ring_fall && state_reg.resume_enable_mask[`RM_RING]) begin
			state_next.ring_latch = 1'b1;
		end

		// Pulse events are latched so a temporary-on routine only delays them.
		state_next.held = state_reg.held;
		if (power_mode == mode_high && !temp_on) begin
			state_next.held = 1'b0;
		end
		if ((ring_fall && state_reg.resume_enable_mask[`RM_RING])
			|| (ac_power_present_rise && state_reg.activity_enable_mask_one[`AM_AC_POWER_PRESENT]
			&& state_reg.power_control_three[`PC3_AC_POWER_PRESENT])
			|| susres_edge) begin
			state_next.held = 1'b1;
		end

		// Wake request toward the mode machine, withheld in temporary-on.
		demand = (|state_reg.pending) | state_reg.held;
		service = demand && !temp_on;
		state_next.go_hs = service && (is_deep(power_mode) || is_slow(power_mode));
		state_next.act = service && is_slow(power_mode) && !state_reg.go_hs;

		// Flags that hardware sets this cycle.
		resume_set = `RESET_BYTE;
		resume_set[`RM_IRQ3] = state_next.pending[7] & ~state_reg.pending[7];
		resume_set[`RM_IRQ4] = state_next.pending[8] & ~state_reg.pending[8];
		resume_set[`RM_IRQ8] = state_next.pending[9] & ~state_reg.pending[9];
		resume_set[`RM_RING] = state_reg.ring_latch;
		resume_set[`RM_SUSRES] = susres_edge;
		activity_set = `RESET_BYTE;
		activity_set[`AM_DRQ1] = state_next.pending[0] & ~state_reg.pending[0];
		activity_set[`AM_DRQ23] = |(state_next.pending[2:1] & ~state_reg.pending[2:1]);
		activity_set[`AM_DRQ567] = |(state_next.pending[5:3] & ~state_reg.pending[5:3]);
		activity_set[`AM_IRQ1] = state_next.pending[6] & ~state_reg.pending[6];
		activity_set[`AM_AC_POWER_PRESENT] = ac_power_present_rise & state_reg.activity_enable_mask_one[`AM_AC_POWER_PRESENT]
			& state_reg.power_control_three[`PC3_AC_POWER_PRESENT];

		// ********************************************************
		// APB slave
		// ********************************************************

		// One wait state: pready rises in the second access cycle.
		idx = reg_index(apb_req.paddr);
		access = apb_req.psel && apb_req.penable && !state_reg.rsp.pready;
		hit = 1'b1;
		rd_byte = `RESET_BYTE;
		case (idx)
			{1'b0, `IDX_RESUME_MASK}: begin
				rd_byte = state_reg.resume_enable_mask;
			end
			{1'b0, `IDX_RESUME_FLAGS}: begin
				rd_byte = state_reg.resume_event_flags;
			end
			{1'b0, `IDX_ACT_MASK_ONE}: begin
				rd_byte = state_reg.activity_enable_mask_one;
			end
			{1'b0, `IDX_ACT_FLAGS}: begin
				rd_byte = state_reg.activity_event_flags;
			end
			{1'b0, `IDX_PWR_CTRL_THREE}: begin
				rd_byte = state_reg.power_control_three;
			end
			{1'b0, `IDX_WAKE_CONFIG}: begin
				rd_byte = state_reg.wake_config;
			end
			{1'b0, `IDX_WAKE_STATE}: begin
				rd_byte = {4'h0, state_reg.ring_latch, state_reg.held,
					state_reg.go_hs, |state_reg.pending};
			end
			default: begin
				hit = 1'b0;
			end
		endcase

		// Writes land at the edge that shows pready high.
		state_next.rsp.pready = access;
		state_next.rsp.pslverr = access && !hit;
		state_next.rsp.prdata = `RESET_WORD;
		if (access && !apb_req.pwrite) begin
			state_next.rsp.prdata = {24'h000000, rd_byte};
		end
		if (state_reg.rsp.pready && apb_req.pwrite) begin
			case (idx)
				{1'b0, `IDX_RESUME_MASK}: begin
					state_next.resume_enable_mask = apb_req.pwdata[7:0];
				end
				{1'b0, `IDX_RESUME_FLAGS}: begin
					state_next.resume_event_flags = `RESET_BYTE;
				end
				{1'b0, `IDX_ACT_MASK_ONE}: begin
					state_next.activity_enable_mask_one = apb_req.pwdata[7:0];
				end
				{1'b0, `IDX_ACT_FLAGS}: begin
					state_next.activity_event_flags = `RESET_BYTE;
				end
				{1'b0, `IDX_PWR_CTRL_THREE}: begin
					state_next.power_control_three = apb_req.pwdata[7:0];
				end
				{1'b0, `IDX_WAKE_CONFIG}: begin
					state_next.wake_config = apb_req.pwdata[7:0];
				end
				default: begin
				end
			endcase
		end

		// A set in the same cycle as a clear wins, so nothing is lost;
		// the ring flag keeps reasserting until the refresh passes.
		state_next.resume_event_flags = state_next.resume_event_flags | resume_set;
		state_next.activity_event_flags = state_next.activity_event_flags
			| activity_set;
	end

	// ************************************************************
	// Registers
	// ************************************************************

	// Synchronous reset puts every field at a constant.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state_reg.sync_one <= `RESET_IN;
			state_reg.sync_two <= `RESET_IN;
			state_reg.last <= `RESET_IN;
			state_reg.or_last <= 1'b0;
			state_reg.pending <= `RESET_SRC;
			state_reg.ring_latch <= 1'b0;
			state_reg.held <= 1'b0;
			state_reg.resume_enable_mask <= `RESET_BYTE;
			state_reg.resume_event_flags <= `RESET_BYTE;
			state_reg.activity_enable_mask_one <= `RESET_BYTE;
			state_reg.activity_event_flags <= `RESET_BYTE;
			state_reg.power_control_three <= `RESET_BYTE;
			state_reg.wake_config <= `RESET_BYTE;
			state_reg.rsp.prdata <= `RESET_WORD;
			state_reg.rsp.pready <= 1'b0;
			state_reg.rsp.pslverr <= 1'b0;
			state_reg.go_hs <= 1'b0;
			state_reg.act <= 1'b0;
		end else begin
			state_reg <= state_next;
		end
	end

	// Outputs come straight from the state flops.
	assign apb_rsp = state_reg.rsp;
	assign go_high_speed = state_reg.go_hs;
	assign activity_pulse = state_reg.act;

endmodule // pmu_wakeup_logic

// >>> hw/wakeup_pkg.sv
// Types shared by the wake-up logic and its bench.
package wakeup_pkg;
	typedef enum logic [2:0] {
		mode_high = 3'b000,
		mode_low = 3'b001,
		mode_doze = 3'b010,
		mode_sleep = 3'b011,
		mode_suspend = 3'b100,
		mode_off = 3'b101
	} power_mode_type;
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} apb_req_type;
	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} apb_rsp_type;
	typedef struct packed {
		logic [7:0] drq;
		logic irq1;
		logic irq3;
		logic irq4;
		logic irq8;
		logic ring_n;
		logic ac_power_present;
		logic suspend_resume_pin;
	} wake_lines_type;
endpackage

// >>> hw/wakeup_regs.svh
// Register indexes, field positions and reset values of the wake-up logic.
`ifndef WAKEUP_REGS_SVH
`define WAKEUP_REGS_SVH
// Register indexes; the byte address on the bus is four times the index.
`define IDX_RESUME_MASK 8'h08
`define IDX_RESUME_FLAGS 8'h09
`define IDX_ACT_MASK_ONE 8'h75
`define IDX_ACT_FLAGS 8'hA0
`define IDX_PWR_CTRL_THREE 8'hAD
`define IDX_WAKE_CONFIG 8'hB8
`define IDX_WAKE_STATE 8'hB9
// Resume mask and resume flag bit positions.
`define RM_IRQ3 3
`define RM_IRQ4 4
`define RM_RING 5
`define RM_IRQ8 6
`define RM_SUSRES 7
// First activity mask and activity flag bit positions.
`define AM_DRQ1 0
`define AM_DRQ23 2
`define AM_DRQ567 3
`define AM_IRQ1 4
`define AM_AC_POWER_PRESENT 6
// Third power control bit that also enables the power-present wake-up.
`define PC3_AC_POWER_PRESENT 4
// Configuration bit that selects the local-bus DRQ set.
`define CFG_LOCAL_BUS 0
// Reset values.
`define RESET_BYTE 8'h00
`define RESET_SRC 10'h000
`define RESET_IN 13'h0000
`define RESET_WORD 32'h0000_0000
// Width of the wake-up line group.
`define SRC_COUNT 10
`define IN_COUNT 13
`endif
